// [hdl/crc_engine_regs.vh]
// register offsets, fields and reset values of the crc engine
`ifndef CRC_ENGINE_REGS_VH
`define CRC_ENGINE_REGS_VH
`define CRC_ADDR_W          4
`define CRC_OFF_CTRL0       4'h0
`define CRC_OFF_CTRL1       4'h1
`define CRC_OFF_IN_LOW      4'h2
`define CRC_OFF_IN_HIGH     4'h3
`define CRC_OFF_ACC_LOW     4'h4
`define CRC_OFF_ACC_HIGH    4'h5
`define CRC_OFF_POLY_LOW    4'h6
`define CRC_OFF_POLY_HIGH   4'h7
`define CRC_OFF_SHIFT_LOW   4'h8
`define CRC_OFF_SHIFT_HIGH  4'h9
`define CRC_CTRL0_ENABLE    0
`define CRC_CTRL0_BUSY      1
`define CRC_CTRL0_ORDER     2
`define CRC_CTRL0_SCAN      3
`define CRC_CTRL0_WMASK     8'h0D
`define CRC_CTRL1_POLY_LEN_LSB 0
`define CRC_CTRL1_DATA_LEN_LSB 4
`define CRC_LEN_W           4
`define CRC_RST_BYTE        8'h00
`define CRC_RST_WORD        16'h0000
`define CRC_BITS_ONE        5'h01
`endif

// [hdl/crc_bit_step.v]
// one accumulator step for a single data bit
module crc_bit_step #(
    parameter WIDTH = 16
) (
    // accumulator in and out, polynomial, length and data bit
    input  wire [WIDTH-1:0] acc_in,
    input  wire [WIDTH-1:0] poly,
    input  wire [3:0]       poly_len,
    input  wire             data_bit,
    output reg  [WIDTH-1:0] acc_out
);
    integer i;
    reg fb;
    // shift left, fold in the polynomial when top bit xor data is one
    always @* begin
        fb = acc_in[poly_len] ^ data_bit;
        for (i = WIDTH-1; i > 0; i = i - 1) begin
            acc_out[i] = (i <= poly_len) ? (acc_in[i-1] ^ (fb & poly[i])) : 1'b0;
        end
        acc_out[0] = fb;
    end
endmodule // crc_bit_step

// [hdl/programmable_crc_engine.v]
// programmable crc engine with register port and scanner input
`include "crc_engine_regs.vh"
module programmable_crc_engine #(
    parameter WIDTH = 16
) (
    // clock and reset
    input  wire                    clk,
    input  wire                    srst,
    // register port
    input  wire [`CRC_ADDR_W-1:0]  addr,
    input  wire [7:0]              wdata,
    input  wire                    wr,
    input  wire                    rd,
    output reg  [7:0]              rdata,
    // program memory scanner
    input  wire                    scan_valid,
    input  wire [15:0]             scan_word,
    output wire                    scan_ready,
    // status
    output wire                    busy
);
    // control and data registers
    reg  [7:0]       ctrl0_q;
    reg  [7:0]       ctrl1_q;
    reg  [7:0]       in_low_q;
    reg  [7:0]       in_high_q;
    reg  [15:0]      acc_q;
    reg  [15:0]      poly_q;
    reg  [15:0]      shift_q;
    reg  [4:0]       bits_left_q;
    reg              busy_q;
    // next values of the datapath registers
    reg  [15:0]      acc_d;
    reg  [15:0]      shift_d;
    reg  [4:0]       bits_left_d;
    reg              busy_d;
    // decoded control fields
    wire             enable;
    wire             order_lsb;
    wire             scan_sel;
    wire [3:0]       poly_len;
    wire [3:0]       data_len;
    // one write strobe per writable register
    wire             wr_ctrl0;
    wire             wr_ctrl1;
    wire             wr_in_low;
    wire             wr_in_high;
    wire             wr_acc_low;
    wire             wr_acc_high;
    wire             wr_poly_low;
    wire             wr_poly_high;
    // datapath
    wire [15:0]      poly_eff;
    wire             data_bit;
    wire [WIDTH-1:0] acc_next;
    wire [15:0]      acc_step;
    wire             sw_load;
    wire             scan_load;
    wire             word_load;
    wire [15:0]      load_word;

    // mask of the bits at or below a length field
    function [15:0] len_mask;
        input [3:0] len;
        begin
            len_mask = 16'hFFFF >> (4'hF - len);
        end
    endfunction

    // write strobe aimed at one register offset
    function reg_hit;
        input                   strobe;
        input [`CRC_ADDR_W-1:0] index;
        input [`CRC_ADDR_W-1:0] offset;
        begin
            reg_hit = strobe & (index == offset);
        end
    endfunction

    // step result in a 16-bit word, unused top bits cleared
    function [15:0] widen_acc;
        input [WIDTH-1:0] value;
        integer j;
        begin
            widen_acc = 16'h0000;
            for (j = 0; j < WIDTH; j = j + 1) begin
                widen_acc[j] = value[j];
            end
        end
    endfunction

    // control fields
    assign enable    = ctrl0_q[`CRC_CTRL0_ENABLE];
    assign order_lsb = ctrl0_q[`CRC_CTRL0_ORDER];
    assign scan_sel  = ctrl0_q[`CRC_CTRL0_SCAN];
    assign poly_len  = ctrl1_q[`CRC_CTRL1_POLY_LEN_LSB +: `CRC_LEN_W];
    assign data_len  = ctrl1_q[`CRC_CTRL1_DATA_LEN_LSB +: `CRC_LEN_W];

    // register write decode
    assign wr_ctrl0     = reg_hit(wr, addr, `CRC_OFF_CTRL0);
    assign wr_ctrl1     = reg_hit(wr, addr, `CRC_OFF_CTRL1);
    assign wr_in_low    = reg_hit(wr, addr, `CRC_OFF_IN_LOW);
    assign wr_in_high   = reg_hit(wr, addr, `CRC_OFF_IN_HIGH);
    assign wr_acc_low   = reg_hit(wr, addr, `CRC_OFF_ACC_LOW);
    assign wr_acc_high  = reg_hit(wr, addr, `CRC_OFF_ACC_HIGH);
    assign wr_poly_low  = reg_hit(wr, addr, `CRC_OFF_POLY_LOW);
    assign wr_poly_high = reg_hit(wr, addr, `CRC_OFF_POLY_HIGH);

    // force lsb to one, msb is the implicit feedback term
    assign poly_eff = (poly_q & len_mask(poly_len)) | 16'h0001;

    // msb first from the data length down, or lsb first
    assign data_bit = order_lsb ? shift_q[0] : shift_q[data_len];

    // one bit per clock into the accumulator
    crc_bit_step #(
        .WIDTH (WIDTH)
    ) u_step (
        .acc_in   (acc_q[WIDTH-1:0]),
        .poly     (poly_eff[WIDTH-1:0]),
        .poly_len (poly_len),
        .data_bit (data_bit),
        .acc_out  (acc_next)
    );
    // accumulator kept to poly length plus one bits
    assign acc_step = widen_acc(acc_next) & len_mask(poly_len);

    // new word only when the shift stage is empty
    assign busy       = busy_q;
    // scanner words accepted when enabled, selected and idle
    assign scan_ready = enable & scan_sel & ~busy_q;
    assign scan_load  = scan_valid & scan_ready;
    // write to low byte latches whole word when enabled, scanner not selected and idle
    assign sw_load    = wr_in_low & enable & ~scan_sel & ~busy_q;
    assign word_load  = sw_load | scan_load;
    // bits above the data length are dropped
    assign load_word  = (scan_load ? scan_word : {in_high_q, wdata}) & len_mask(data_len);

    // control registers, busy bit is read only
    always @(posedge clk) begin
        if (srst) begin
            ctrl0_q <= `CRC_RST_BYTE;
            ctrl1_q <= `CRC_RST_BYTE;
        end else begin
            if (wr_ctrl0) begin
                ctrl0_q <= wdata & `CRC_CTRL0_WMASK;
            end
            if (wr_ctrl1) begin
                ctrl1_q <= wdata;
            end
        end
    end

    // input data bytes, kept for read back
    always @(posedge clk) begin
        if (srst) begin
            in_low_q  <= `CRC_RST_BYTE;
            in_high_q <= `CRC_RST_BYTE;
        end else begin
            if (wr_in_low) begin
                in_low_q <= wdata;
            end
            if (wr_in_high) begin
                in_high_q <= wdata;
            end
        end
    end

    // polynomial terms, bit zero never stored
    always @(posedge clk) begin
        if (srst) begin
            poly_q <= `CRC_RST_WORD;
        end else begin
            if (wr_poly_low) begin
                poly_q[7:0] <= {wdata[7:1], 1'b0};
            end
            if (wr_poly_high) begin
                poly_q[15:8] <= wdata;
            end
        end
    end

    // seed writes while idle, one step per busy cycle
    always @* begin
        acc_d = acc_q;
        if (busy_q) begin
            acc_d = acc_step;
        end else begin
            if (wr_acc_low) begin
                acc_d[7:0] = wdata;
            end
            if (wr_acc_high) begin
                acc_d[15:8] = wdata;
            end
        end
    end

    // shift stage loaded first, then drained a bit a cycle
    always @* begin
        shift_d     = shift_q;
        bits_left_d = bits_left_q;
        busy_d      = busy_q;
        if (word_load) begin
            shift_d     = load_word;
            bits_left_d = {1'b0, data_len} + `CRC_BITS_ONE;
            busy_d      = 1'b1;
        end else if (busy_q) begin
            // next bit moves into the tap
            if (order_lsb) begin
                shift_d = {1'b0, shift_q[15:1]};
            end else begin
                shift_d = {shift_q[14:0], 1'b0};
            end
            bits_left_d = bits_left_q - `CRC_BITS_ONE;
            // idle again once the last bit is in
            if (bits_left_q == `CRC_BITS_ONE) begin
                busy_d = 1'b0;
            end
        end
    end

    // datapath registers
    always @(posedge clk) begin
        if (srst) begin
            acc_q       <= `CRC_RST_WORD;
            shift_q     <= `CRC_RST_WORD;
            bits_left_q <= 5'h00;
            busy_q      <= 1'b0;
        end else begin
            acc_q       <= acc_d;
            shift_q     <= shift_d;
            bits_left_q <= bits_left_d;
            busy_q      <= busy_d;
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always @(posedge clk) begin
        if (srst) begin
            rdata <= `CRC_RST_BYTE;
        end else if (rd) begin
            case (addr)
                `CRC_OFF_CTRL0: rdata <= {ctrl0_q[7:2], busy_q, ctrl0_q[0]};
                `CRC_OFF_CTRL1:      rdata <= ctrl1_q;
                `CRC_OFF_IN_LOW:     rdata <= in_low_q;
                `CRC_OFF_IN_HIGH:    rdata <= in_high_q;
                `CRC_OFF_ACC_LOW:    rdata <= acc_q[7:0];
                `CRC_OFF_ACC_HIGH:   rdata <= acc_q[15:8];
                `CRC_OFF_POLY_LOW:   rdata <= {poly_q[7:1], 1'b0};
                `CRC_OFF_POLY_HIGH:  rdata <= poly_q[15:8];
                `CRC_OFF_SHIFT_LOW:  rdata <= shift_q[7:0];
                `CRC_OFF_SHIFT_HIGH: rdata <= shift_q[15:8];
                default:             rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule // programmable_crc_engine

// [sim/crc_scan_model.sv]
// scanner stand-in offering one word per request
module crc_scan_model (
    // clock and reset
    input  wire         clk,
    input  wire         srst,
    // request from the bench
    input  wire         go,
    input  wire  [15:0] word,
    // scanner handshake
    input  wire         scan_ready,
    output logic        scan_valid,
    output logic [15:0] scan_word
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge clk) begin
        if (srst) begin
            scan_valid <= 1'b0;
            scan_word  <= 16'h0000;
        end else if (scan_valid && scan_ready) begin
            scan_valid <= 1'b0;
            scan_word  <= ~scan_word; // stale word scrambled
        end else if (go) begin
            scan_valid <= 1'b1;
            scan_word  <= word;
        end
    end
endmodule // crc_scan_model

// [sim/programmable_crc_engine_monitor.sv]
// port assertions of the crc engine
module crc_engine_monitor (
    // clock, reset and bus
    input wire       clk,
    input wire       srst,
    input wire [3:0] addr,
    input wire       wr,
    input wire       rd,
    input wire [7:0] rdata,
    // scanner and status
    input wire       scan_valid,
    input wire       scan_ready,
    input wire       busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // port relations
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata idle");
    a_ready_busy: assert property (scan_ready |-> !busy) else $error("ready busy");
    a_scan_load: assert property (scan_valid && scan_ready |=> busy) else $error("scan load");
    a_busy_cause: assert property ($rose(busy) |-> $past(wr && addr == 4'h2
        || scan_valid && scan_ready)) else $error("busy cause");
    a_busy_len: assert property ($rose(busy) |-> ##[1:16] !busy) else $error("busy len");
    a_busy_bit: assert property ($past(rd && addr == 4'h0)
        |-> rdata[1] == $past(busy)) else $error("busy bit");
    a_poly_lsb: assert property ($past(rd && addr == 4'h6)
        |-> !rdata[0]) else $error("poly lsb");
    a_unmapped_read: assert property ($past(rd && addr > 4'h9) |-> rdata == 8'h00)
        else $error("unmapped");
    // main scenarios
    c_scan: cover property (scan_valid && scan_ready);
    c_busy: cover property ($rose(busy));
    c_done: cover property ($fell(busy));
endmodule // crc_engine_monitor
bind programmable_crc_engine crc_engine_monitor mon_u (.clk(clk), .srst(srst), .addr(addr),
    .wr(wr), .rd(rd), .rdata(rdata), .scan_valid(scan_valid), .scan_ready(scan_ready),
    .busy(busy));

// [sim/programmable_crc_engine_tb.sv]
// self-checking bench of the crc engine
module programmable_crc_engine_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, srst = 1, wr = 0, rd = 0, go = 0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [15:0] sw = 16'h0000;
    wire [7:0] rdata;
    wire [15:0] scan_word;
    wire scan_valid, scan_ready, busy;
    int failures = 0, n_compared = 0, cycles = 0;
    programmable_crc_engine dut_u (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .scan_valid(scan_valid), .scan_word(scan_word),
        .scan_ready(scan_ready), .busy(busy));
    crc_scan_model scan_u (.clk(clk), .srst(srst), .go(go), .word(sw),
        .scan_ready(scan_ready), .scan_valid(scan_valid), .scan_word(scan_word));
    // clock and hang guard
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            failures++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic put(logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic get(logic [3:0] a, output logic [7:0] q);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 q = rdata;
    endtask
    // bitwise model of a w-bit check, terms pt with the lsb forced to one
    function automatic logic [15:0] ref_crc(logic [15:0] acc, logic [15:0] pt, int w,
        logic [15:0] d, int n, bit lsb);
        logic fb;
        logic [15:0] msk;
        msk = 16'((32'h1 << w) - 1);
        for (int i = 0; i < n; i++) begin
            fb = acc[w-1] ^ (lsb ? d[i] : d[n-1-i]);
            acc = ((acc << 1) ^ (fb ? (pt | 16'h0001) : 16'h0000)) & msk;
        end
        return acc;
    endfunction
    task automatic t_regs();
        logic [7:0] q;
        for (int a = 0; a < 16; a++) begin
            get(4'(a), q);
            check("reset read", 16'(q), 16'h0000);
        end
        put(4'h6, 8'hFF);
        get(4'h6, q);
        check("poly low", 16'(q), 16'h00FE);
        $display("test registers done");
    endtask
    task automatic run_word(string nm, logic [7:0] c, logic [15:0] s, logic [15:0] d, int n,
        int p, logic [15:0] pt);
        logic [7:0] lo, hi;
        int k;
        put(4'h1, 8'((n - 1) * 16 + p - 1));
        put(4'h0, c);
        #1 check("scan ready", 16'(scan_ready), 16'(c[3] & c[0]));
        put(4'h6, pt[7:0]);
        put(4'h7, pt[15:8]);
        put(4'h4, s[7:0]);
        put(4'h5, s[15:8]);
        if (c[3]) begin
            put(4'h2, 8'h55);
            #1 check("low write in scan", 16'(busy), 16'h0000);
            @(posedge clk);
            sw <= d;
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
        end else begin
            put(4'h3, d[15:8]);
            put(4'h2, d[7:0]);
        end
        #1;
        for (k = 0; busy !== 1'b1 && k < 8; k++) @(posedge clk) #1;
        for (k = 0; busy === 1'b1 && k < 40; k++) @(posedge clk) #1;
        check("busy cycles", 16'(k), 16'(n));
        get(4'h4, lo);
        get(4'h5, hi);
        check("accumulator", {hi, lo}, ref_crc(s, pt, p, d, n, c[2]));
        $display("test %s done", nm);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        run_word("msb first", 8'h01, 16'hFFFF, 16'hAB31, 8, 16, 16'h8004);
        run_word("lsb first", 8'h05, 16'h0000, 16'h1234, 16, 16, 16'h8004);
        run_word("scanner", 8'h09, 16'h1D0F, 16'h00F0, 13, 16, 16'h8004);
        run_word("short acc", 8'h01, 16'h00FF, 16'h00C5, 8, 8, 16'h0006);
        print_verdict();
    end
endmodule // programmable_crc_engine_tb
